/* File: hw/ttfs_defs.vh */
/*
 Constants of the transform test fixture sequencer: counts, field
 positions, address steps and reset values.
 Assumes inclusion by bare name from the design files.
*/
`ifndef TTFS_DEFS_VH
`define TTFS_DEFS_VH

// ============================================================
// Sequencer counts
`define TTFS_PULSES_PER_CYCLE   10'd516
`define TTFS_PULSE_LAST         10'd515
`define TTFS_DATA_POINTS        10'd512
`define TTFS_GAP_FIRST          10'd512
`define TTFS_CYCLES_PER_FRINGE  9'd256
`define TTFS_CYCLE_LAST         8'hff
`define TTFS_FRINGES_PER_INTEG  6'd32
`define TTFS_FRINGE_LAST        5'h1f

// ============================================================
// Pattern memory
`define TTFS_RAM_ADDR_W         18
`define TTFS_RAM_DEPTH          262144
`define TTFS_START_STEP         18'h01000
`define TTFS_ADDR_RESET         18'h00000

// ============================================================
// Accumulator side
`define TTFS_ACC_ADDR_W         16
`define TTFS_HALF_W             18

// ============================================================
// Register map (word index on the bus)
`define TTFS_REG_CTRL           4'h0
`define TTFS_REG_PAT_ADDR       4'h1
`define TTFS_REG_PAT_DATA       4'h2
`define TTFS_REG_RD_ADDR        4'h3
`define TTFS_REG_ASIC_SEL       4'h4
`define TTFS_REG_HOLD_ADDR      4'h5
`define TTFS_REG_HOLD_DATA      4'h6
`define TTFS_REG_STATUS         4'h7
`define TTFS_REG_SEQ            4'h8

// Control register fields
`define TTFS_CTRL_RUN           0
`define TTFS_CTRL_EXT_DATA      1
`define TTFS_CTRL_CLK_LO        2
`define TTFS_CTRL_CLK_HI        3
`define TTFS_CTRL_LAMP_CLR      4
`define TTFS_CTRL_RESET         5'h00

// Clock source codes
`define TTFS_CLK_VCO            2'b00
`define TTFS_CLK_XTAL           2'b01
`define TTFS_CLK_EXT            2'b10

`endif

/* File: hw/ttfs_pattern_ram.v */
/*
 Pattern memory: eight 64k by 4 parts seen as one 256k deep array of
 four 2-bit streams (8 bits per word). Write port from the processor,
 registered read port from the sequencer.
 Assumes one clock; write and read never need the same word in a cycle.
*/
`timescale 1ns/1ps
`default_nettype none
`include "ttfs_defs.vh"

module ttfs_pattern_ram (
    // Clock
    input  wire                        clk,
    // Write port
    input  wire                        wr_en,
    input  wire [`TTFS_RAM_ADDR_W-1:0] wr_addr,
    input  wire [7:0]                  wr_data,
    // Read port
    input  wire [`TTFS_RAM_ADDR_W-1:0] rd_addr,
    output reg  [7:0]                  rd_data
);

    reg [7:0] mem [0:`TTFS_RAM_DEPTH-1];

    always @(posedge clk) begin
        if (wr_en) begin
            mem[wr_addr] <= wr_data;
        end
        rd_data <= mem[rd_addr];
    end

endmodule // ttfs_pattern_ram

`default_nettype wire

/* File: hw/ttfs_top.v */
/*
 Transform test fixture sequencer. Three-level sequencer, control
 decode, pattern streams with stepping start address, accumulator
 address and readout path, overflow lamps, clock source select.
 Assumes one 20 MHz clock, Avalon-MM slave with waitrequest, and that
 the transform card and accumulator card sit on the same clock.
*/
// Design decisions made here: the Avalon-MM slave port and the address map.
`timescale 1ns/1ps
`default_nettype none
`include "ttfs_defs.vh"

module ttfs_top (
    // Clock and reset
    input  wire        CLK_SYS,
    input  wire        NRST,
    // Avalon-MM slave
    input  wire [3:0]  AVS_ADDRESS,
    input  wire        AVS_READ,
    input  wire        AVS_WRITE,
    input  wire [31:0] AVS_WRITEDATA,
    output reg  [31:0] AVS_READDATA,
    output wire        AVS_WAITREQUEST,
    // Front panel
    input  wire        EXT_DATA_SEL,
    input  wire        LAMP_RESET_BTN_N,
    output reg  [1:0]  CLK_SOURCE_SEL,
    output reg  [3:0]  OVERFLOW_LAMP,
    // External data and transform card
    input  wire [7:0]  EXT_DATA,
    input  wire [1:0]  INPUT_SELECT,
    input  wire [3:0]  EXPONENT_OVERFLOW_N,
    output reg  [31:0] PIPE_DATA,
    output reg         CONTROLLER_INIT,
    output reg         CYCLE_ACTIVE,
    // Transform output buses to accumulator card
    input  wire [17:0] XFORM_BUS_A,
    input  wire [17:0] XFORM_BUS_B,
    output reg  [71:0] ACC_IN_A,
    output reg  [71:0] ACC_IN_B,
    // Accumulator card control
    output reg  [15:0] ACC_EXT_ADDR,
    output reg         ACCUMULATOR_WRITE_STROBE,
    output reg         SHORT_ACCUM_READ_STROBE,
    output reg         HALF_WORD_SELECT,
    output reg         CARD_SELECT_N,
    output reg         ASIC_ROW_SELECT_0,
    output reg         ASIC_ROW_SELECT_1,
    output reg         ASIC_COLUMN_SELECT_0,
    output reg         ASIC_COLUMN_SELECT_1,
    input  wire [17:0] ACC_RESULT
);

    // ============================================================
    // Reset and input synchronisers
    reg       rst_s1_q;
    reg       rst_n_q;
    reg [7:0] sync1_q;
    reg [7:0] sync2_q;

    always @(posedge CLK_SYS or negedge NRST) begin
        if (!NRST) begin
            rst_s1_q <= 1'b0;
            rst_n_q  <= 1'b0;
        end else begin
            rst_s1_q <= 1'b1;
            rst_n_q  <= rst_s1_q;
        end
    end

    // Panel switch, lamp button and overflow pins are asynchronous
    always @(posedge CLK_SYS or negedge rst_n_q) begin
        if (!rst_n_q) begin
            sync1_q <= 8'hfb;
            sync2_q <= 8'hfb;
        end else begin
            sync1_q <= {EXPONENT_OVERFLOW_N, LAMP_RESET_BTN_N,
                        EXT_DATA_SEL, 2'b11};
            sync2_q <= sync1_q;
        end
    end

    wire       ext_sel_s   = sync2_q[2];
    wire       lamp_btn_s  = ~sync2_q[3];
    wire [3:0] expo_ovf_s  = ~sync2_q[7:4];

    // ============================================================
    // Registers
    reg [4:0]  ctrl_q;
    reg [17:0] pat_addr_q;
    reg [15:0] rd_addr_q;
    reg [5:0]  asic_sel_q;
    reg [15:0] hold_addr_q;
    reg [17:0] hold_data_q;
    reg        ack_q;

    wire run    = ctrl_q[`TTFS_CTRL_RUN];
    wire access = (AVS_READ | AVS_WRITE) & ~ack_q;
    assign AVS_WAITREQUEST = (AVS_READ | AVS_WRITE) & ~ack_q;

    wire pat_we = access & AVS_WRITE & (AVS_ADDRESS == `TTFS_REG_PAT_DATA);

    // ============================================================
    // Sequencer
    reg [9:0]  pulse_q;
    reg [7:0]  cycle_q;
    reg [4:0]  fringe_q;
    reg [17:0] start_q;
    reg [17:0] ram_addr_q;

    wire pulse_wrap  = (pulse_q == `TTFS_PULSE_LAST);
    wire cycle_wrap  = pulse_wrap & (cycle_q == `TTFS_CYCLE_LAST);
    wire fringe_wrap = cycle_wrap & (fringe_q == `TTFS_FRINGE_LAST);
    wire in_gap      = (pulse_q >= `TTFS_GAP_FIRST);

    always @(posedge CLK_SYS or negedge rst_n_q) begin
        if (!rst_n_q) begin
            pulse_q    <= 10'h000;
            cycle_q    <= 8'h00;
            fringe_q   <= 5'h00;
            start_q    <= `TTFS_ADDR_RESET;
            ram_addr_q <= `TTFS_ADDR_RESET;
        end else if (!run) begin
            pulse_q    <= 10'h000;
            cycle_q    <= 8'h00;
            fringe_q   <= 5'h00;
            start_q    <= `TTFS_ADDR_RESET;
            ram_addr_q <= `TTFS_ADDR_RESET;
        end else begin
            pulse_q <= pulse_wrap ? 10'h000 : pulse_q + 10'h001;
            if (pulse_wrap) begin
                cycle_q <= cycle_q + 8'h01;
            end
            if (fringe_wrap) begin
                fringe_q   <= 5'h00;
                start_q    <= `TTFS_ADDR_RESET;
                ram_addr_q <= `TTFS_ADDR_RESET;
            end else if (cycle_wrap) begin
                fringe_q   <= fringe_q + 5'h01;
                start_q    <= start_q + `TTFS_START_STEP;
                ram_addr_q <= start_q + `TTFS_START_STEP;
            end else if (!in_gap) begin
                ram_addr_q <= ram_addr_q + 18'h00001;
            end
        end
    end

    // Control decode from all three levels (pulse, cycle, fringe)
    always @(posedge CLK_SYS or negedge rst_n_q) begin
        if (!rst_n_q) begin
            CONTROLLER_INIT          <= 1'b0;
            CYCLE_ACTIVE             <= 1'b0;
            ACCUMULATOR_WRITE_STROBE <= 1'b0;
            SHORT_ACCUM_READ_STROBE  <= 1'b0;
            ACC_EXT_ADDR             <= 16'h0000;
        end else begin
            CONTROLLER_INIT <= run & (pulse_q == 10'h000) &
                               (cycle_q == 8'h00) & (fringe_q == 5'h00);
            CYCLE_ACTIVE    <= run & ~in_gap;
            ACCUMULATOR_WRITE_STROBE <= run & in_gap;
            SHORT_ACCUM_READ_STROBE  <= run & in_gap &
                                        (pulse_q == `TTFS_PULSE_LAST);
            if (run & in_gap) begin
                ACC_EXT_ADDR <= rd_addr_q;
            end else begin
                ACC_EXT_ADDR <= {cycle_q, pulse_q[7:0]};
            end
        end
    end

    // ============================================================
    // Pattern streams
    wire [7:0] ram_data;

    ttfs_pattern_ram u_pattern_ram (
        .clk     (CLK_SYS),
        .wr_en   (pat_we),
        .wr_addr (pat_addr_q),
        .wr_data (AVS_WRITEDATA[7:0]),
        .rd_addr (ram_addr_q),
        .rd_data (ram_data)
    );

    function [7:0] ttfs_spread;
        input [1:0] val;
        input [1:0] sel;
        reg   [7:0] r;
        integer     k;
        begin
            r = 8'h00;
            for (k = 0; k < 4; k = k + 1) begin
                if (k[1:0] == sel) begin
                    r[2*k +: 2] = val;
                end else begin
                    r[2*k +: 2] = {2{val[0] ^ val[1]}};
                end
            end
            ttfs_spread = r;
        end
    endfunction

    wire [7:0] src = (ext_sel_s | ctrl_q[`TTFS_CTRL_EXT_DATA]) ?
                     EXT_DATA : ram_data;

    integer p;
    always @(posedge CLK_SYS or negedge rst_n_q) begin
        if (!rst_n_q) begin
            PIPE_DATA <= 32'h00000000;
            ACC_IN_A  <= 72'h0;
            ACC_IN_B  <= 72'h0;
        end else begin
            for (p = 0; p < 4; p = p + 1) begin
                PIPE_DATA[8*p +: 8] <= ttfs_spread(src[2*p +: 2],
                                                   INPUT_SELECT);
            end
            ACC_IN_A <= {4{XFORM_BUS_A}};
            ACC_IN_B <= {4{XFORM_BUS_B}};
        end
    end

    // ============================================================
    // Readout holding register and overflow lamps
    always @(posedge CLK_SYS or negedge rst_n_q) begin
        if (!rst_n_q) begin
            hold_addr_q   <= 16'h0000;
            hold_data_q   <= 18'h00000;
            OVERFLOW_LAMP <= 4'h0;
        end else begin
            if (SHORT_ACCUM_READ_STROBE) begin
                hold_addr_q <= ACC_EXT_ADDR;
                hold_data_q <= ACC_RESULT;
            end
            if (lamp_btn_s) begin
                OVERFLOW_LAMP <= expo_ovf_s;
            end else begin
                OVERFLOW_LAMP <= OVERFLOW_LAMP | expo_ovf_s;
            end
        end
    end

    // ============================================================
    // Bus slave
    always @(posedge CLK_SYS or negedge rst_n_q) begin
        if (!rst_n_q) begin
            ack_q                <= 1'b0;
            ctrl_q               <= `TTFS_CTRL_RESET;
            pat_addr_q           <= `TTFS_ADDR_RESET;
            rd_addr_q            <= 16'h0000;
            asic_sel_q           <= 6'h01;
            AVS_READDATA         <= 32'h00000000;
            CLK_SOURCE_SEL       <= `TTFS_CLK_XTAL;
            HALF_WORD_SELECT     <= 1'b0;
            CARD_SELECT_N        <= 1'b1;
            ASIC_ROW_SELECT_0    <= 1'b0;
            ASIC_ROW_SELECT_1    <= 1'b0;
            ASIC_COLUMN_SELECT_0 <= 1'b0;
            ASIC_COLUMN_SELECT_1 <= 1'b0;
        end else begin
            ack_q <= access;
            if (access & AVS_WRITE) begin
                if (AVS_ADDRESS == `TTFS_REG_CTRL) begin
                    ctrl_q <= AVS_WRITEDATA[4:0];
                    CLK_SOURCE_SEL <= AVS_WRITEDATA[3:2];
                end else if (AVS_ADDRESS == `TTFS_REG_PAT_ADDR) begin
                    pat_addr_q <= AVS_WRITEDATA[17:0];
                end else if (AVS_ADDRESS == `TTFS_REG_PAT_DATA) begin
                    pat_addr_q <= pat_addr_q + 18'h00001;
                end else if (AVS_ADDRESS == `TTFS_REG_RD_ADDR) begin
                    rd_addr_q <= AVS_WRITEDATA[15:0];
                end else if (AVS_ADDRESS == `TTFS_REG_ASIC_SEL) begin
                    CARD_SELECT_N        <= AVS_WRITEDATA[0];
                    ASIC_ROW_SELECT_0    <= AVS_WRITEDATA[1];
                    ASIC_ROW_SELECT_1    <= AVS_WRITEDATA[2];
                    ASIC_COLUMN_SELECT_0 <= AVS_WRITEDATA[3];
                    ASIC_COLUMN_SELECT_1 <= AVS_WRITEDATA[4];
                    HALF_WORD_SELECT     <= AVS_WRITEDATA[5];
                    asic_sel_q           <= AVS_WRITEDATA[5:0];
                end
            end
            if (access & AVS_READ) begin
                if (AVS_ADDRESS == `TTFS_REG_CTRL) begin
                    AVS_READDATA <= {27'h0, ctrl_q};
                end else if (AVS_ADDRESS == `TTFS_REG_PAT_ADDR) begin
                    AVS_READDATA <= {14'h0, pat_addr_q};
                end else if (AVS_ADDRESS == `TTFS_REG_RD_ADDR) begin
                    AVS_READDATA <= {16'h0, rd_addr_q};
                end else if (AVS_ADDRESS == `TTFS_REG_ASIC_SEL) begin
                    AVS_READDATA <= {26'h0, asic_sel_q};
                end else if (AVS_ADDRESS == `TTFS_REG_HOLD_ADDR) begin
                    AVS_READDATA <= {16'h0, hold_addr_q};
                end else if (AVS_ADDRESS == `TTFS_REG_HOLD_DATA) begin
                    AVS_READDATA <= {14'h0, hold_data_q};
                end else if (AVS_ADDRESS == `TTFS_REG_STATUS) begin
                    AVS_READDATA <= {26'h0, ext_sel_s, run, OVERFLOW_LAMP};
                end else if (AVS_ADDRESS == `TTFS_REG_SEQ) begin
                    AVS_READDATA <= {9'h0, fringe_q, cycle_q, pulse_q};
                end else begin
                    AVS_READDATA <= 32'h00000000;
                end
            end
        end
    end

endmodule // ttfs_top

`default_nettype wire

/* File: tb/ttfs_checker.sv */
/* Assertion checker for ttfs_top, bound at its ports.
   Assumes one clock and the active-low asynchronous NRST. */
`timescale 1ns/1ps
`default_nettype none

module ttfs_checker (
    // Clock and reset
    input wire logic        CLK_SYS,
    input wire logic        NRST,
    // Bus and panel
    input wire logic        AVS_READ,
    input wire logic        AVS_WRITE,
    input wire logic        AVS_WAITREQUEST,
    input wire logic        LAMP_RESET_BTN_N,
    input wire logic [3:0]  OVERFLOW_LAMP,
    // Sequencer and accumulator side
    input wire logic        CYCLE_ACTIVE,
    input wire logic        CONTROLLER_INIT,
    input wire logic [17:0] XFORM_BUS_A,
    input wire logic [17:0] XFORM_BUS_B,
    input wire logic [71:0] ACC_IN_A,
    input wire logic [71:0] ACC_IN_B,
    input wire logic [15:0] ACC_EXT_ADDR,
    input wire logic        ACCUMULATOR_WRITE_STROBE,
    input wire logic        SHORT_ACCUM_READ_STROBE
);
    wire logic ca = CYCLE_ACTIVE;
    wire logic we = ACCUMULATOR_WRITE_STROBE;
    wire logic btn = LAMP_RESET_BTN_N;
    logic [9:0] act_q;

    default clocking cb @(posedge CLK_SYS); endclocking
    default disable iff (!NRST);

    // ==========================================================
    // Length of the active part of a transform cycle
    always_ff @(posedge CLK_SYS or negedge NRST) begin
        if (!NRST) act_q <= 10'h000;
        else if (ca) act_q <= act_q + 10'h001;
        else act_q <= 10'h000;
    end

    // ==========================================================
    // Properties
    wait_one_a: assert property (
        $rose(AVS_READ || AVS_WRITE) |-> AVS_WAITREQUEST ##1 !AVS_WAITREQUEST)
        else $error("bus answer not after one wait cycle");
    active_len_a: assert property (
        $fell(ca) |-> act_q == 10'h200)
        else $error("active part not 512 cycles");
    gap_four_a: assert property (
        $fell(ca) |-> !ca [*4] ##1 ca)
        else $error("gap not four cycles");
    strobe_len_a: assert property (
        $rose(we) |-> we [*4] ##1 !we)
        else $error("write strobe not four cycles");
    read_last_a: assert property (
        $rose(we) |-> !SHORT_ACCUM_READ_STROBE [*3] ##1
                      (SHORT_ACCUM_READ_STROBE && we))
        else $error("read strobe not in last gap cycle");
    addr_hold_a: assert property (
        we && $past(we) && $past(we, 2) |-> $stable(ACC_EXT_ADDR))
        else $error("readout address moved in gap");
    addr_step_a: assert property (
        ca && $past(ca) && $past(ca, 2) && !we && !$past(we) |->
        ACC_EXT_ADDR[7:0] == $past(ACC_EXT_ADDR[7:0]) + 8'h01)
        else $error("accumulator address did not step");
    bus_copy_a: assert property (
        $past(NRST, 3) |-> {ACC_IN_A, ACC_IN_B} ==
        {{4{$past(XFORM_BUS_A)}}, {4{$past(XFORM_BUS_B)}}})
        else $error("accumulator inputs not four copies");
    init_pulse_a: assert property (
        CONTROLLER_INIT |=> !CONTROLLER_INIT)
        else $error("init pulse longer than one cycle");
    lamp_hold_a: assert property (
        |(~OVERFLOW_LAMP & $past(OVERFLOW_LAMP)) |->
        !(btn && $past(btn) && $past(btn, 2) && $past(btn, 3)))
        else $error("lamp cleared without button");

    cover property ($fell(ca));
    cover property (SHORT_ACCUM_READ_STROBE);
    cover property (CONTROLLER_INIT);
    cover property (|OVERFLOW_LAMP);
endmodule // ttfs_checker

bind ttfs_top ttfs_checker u_ttfs_checker (
    .CLK_SYS(CLK_SYS), .NRST(NRST), .AVS_READ(AVS_READ),
    .AVS_WRITE(AVS_WRITE), .AVS_WAITREQUEST(AVS_WAITREQUEST),
    .LAMP_RESET_BTN_N(LAMP_RESET_BTN_N), .OVERFLOW_LAMP(OVERFLOW_LAMP),
    .CYCLE_ACTIVE(CYCLE_ACTIVE), .CONTROLLER_INIT(CONTROLLER_INIT),
    .XFORM_BUS_A(XFORM_BUS_A), .XFORM_BUS_B(XFORM_BUS_B),
    .ACC_IN_A(ACC_IN_A), .ACC_IN_B(ACC_IN_B), .ACC_EXT_ADDR(ACC_EXT_ADDR),
    .ACCUMULATOR_WRITE_STROBE(ACCUMULATOR_WRITE_STROBE),
    .SHORT_ACCUM_READ_STROBE(SHORT_ACCUM_READ_STROBE));

`default_nettype wire

/* File: tb/ttfs_far_model.sv */
/* Far-side model: transform card output buses and accumulator ASIC
   readout word. Assumes the fixture clock and registered selects. */
`timescale 1ns/1ps
`default_nettype none

module ttfs_far_model (
    // Clock
    input  wire logic        clk,
    // Accumulator control from the fixture
    input  wire logic [15:0] acc_addr,
    input  wire logic        half_sel,
    input  wire logic        card_sel_n,
    // Data toward the fixture
    output logic      [17:0] xform_a,
    output logic      [17:0] xform_b,
    output logic      [17:0] acc_result
);
    logic [17:0] cnt_q = 18'h00000;

    // Buses change every cycle so a stale copy shows
    always_ff @(posedge clk) cnt_q <= cnt_q + 18'h00001;
    assign xform_a = cnt_q;
    assign xform_b = ~{cnt_q[8:0], cnt_q[17:9]};
    // Deselected card floats: show a moving pattern
    assign acc_result = card_sel_n ? ~cnt_q :
        half_sel ? {2'b01, ~acc_addr} : {2'b10, acc_addr};
endmodule // ttfs_far_model

`default_nettype wire

/* File: tb/test_transform_test_fixture_sequencer.sv */
/* Self-checking bench for ttfs_top: Avalon-MM register tasks, panel and
   stream stimulus, far-side model on the accumulator side.
   Assumes the register map and reset values of the design. */
`timescale 1ns/1ps
`default_nettype none
`include "ttfs_defs.vh"
`define CHK(g, e) begin n_tests++; if ((g) !== (e)) begin num_errors++; \
    $display("BAD t=%0t got %h exp %h", $time, g, e); end end

module test_transform_test_fixture_sequencer;
    logic        CLK_SYS = 1'b0, NRST = 1'b0;
    logic [3:0]  AVS_ADDRESS = 4'h0;
    logic        AVS_READ = 1'b0, AVS_WRITE = 1'b0;
    logic [31:0] AVS_WRITEDATA = 32'h0, AVS_READDATA, rdat;
    logic        AVS_WAITREQUEST, EXT_DATA_SEL = 1'b0;
    logic        LAMP_RESET_BTN_N = 1'b1, CONTROLLER_INIT, CYCLE_ACTIVE;
    logic [1:0]  CLK_SOURCE_SEL, INPUT_SELECT = 2'h0;
    logic [3:0]  OVERFLOW_LAMP, EXPONENT_OVERFLOW_N = 4'hf;
    logic [7:0]  EXT_DATA = 8'hc6, prev, b;
    logic [31:0] PIPE_DATA;
    logic [17:0] XFORM_BUS_A, XFORM_BUS_B, ACC_RESULT;
    logic [71:0] ACC_IN_A, ACC_IN_B;
    logic [15:0] ACC_EXT_ADDR;
    logic        ACCUMULATOR_WRITE_STROBE, SHORT_ACCUM_READ_STROBE;
    logic        HALF_WORD_SELECT, CARD_SELECT_N, mon_on = 1'b0;
    logic        ASIC_ROW_SELECT_0, ASIC_ROW_SELECT_1;
    logic        ASIC_COLUMN_SELECT_0, ASIC_COLUMN_SELECT_1;
    int          num_errors = 0, n_tests = 0, cyc = 0, n_init = 0, run_n = 0;

    always #25 CLK_SYS = ~CLK_SYS;

    ttfs_top u_ttfs_top (
        .CLK_SYS(CLK_SYS), .NRST(NRST), .AVS_ADDRESS(AVS_ADDRESS),
        .AVS_READ(AVS_READ), .AVS_WRITE(AVS_WRITE),
        .AVS_WRITEDATA(AVS_WRITEDATA), .AVS_READDATA(AVS_READDATA),
        .AVS_WAITREQUEST(AVS_WAITREQUEST), .EXT_DATA_SEL(EXT_DATA_SEL),
        .LAMP_RESET_BTN_N(LAMP_RESET_BTN_N), .CLK_SOURCE_SEL(CLK_SOURCE_SEL),
        .OVERFLOW_LAMP(OVERFLOW_LAMP), .EXT_DATA(EXT_DATA),
        .INPUT_SELECT(INPUT_SELECT), .PIPE_DATA(PIPE_DATA),
        .EXPONENT_OVERFLOW_N(EXPONENT_OVERFLOW_N),
        .CONTROLLER_INIT(CONTROLLER_INIT), .CYCLE_ACTIVE(CYCLE_ACTIVE),
        .XFORM_BUS_A(XFORM_BUS_A), .XFORM_BUS_B(XFORM_BUS_B),
        .ACC_IN_A(ACC_IN_A), .ACC_IN_B(ACC_IN_B), .ACC_EXT_ADDR(ACC_EXT_ADDR),
        .ACCUMULATOR_WRITE_STROBE(ACCUMULATOR_WRITE_STROBE),
        .SHORT_ACCUM_READ_STROBE(SHORT_ACCUM_READ_STROBE),
        .HALF_WORD_SELECT(HALF_WORD_SELECT), .CARD_SELECT_N(CARD_SELECT_N),
        .ASIC_ROW_SELECT_0(ASIC_ROW_SELECT_0),
        .ASIC_ROW_SELECT_1(ASIC_ROW_SELECT_1),
        .ASIC_COLUMN_SELECT_0(ASIC_COLUMN_SELECT_0),
        .ASIC_COLUMN_SELECT_1(ASIC_COLUMN_SELECT_1), .ACC_RESULT(ACC_RESULT));

    ttfs_far_model u_ttfs_far_model (
        .clk(CLK_SYS), .acc_addr(ACC_EXT_ADDR), .half_sel(HALF_WORD_SELECT),
        .card_sel_n(CARD_SELECT_N), .xform_a(XFORM_BUS_A),
        .xform_b(XFORM_BUS_B), .acc_result(ACC_RESULT));

    // ==========================================================
    // Tasks
    task automatic end_of_test();
        $display("comparisons %0d mismatches %0d", n_tests, num_errors);
        if (num_errors == 0 && n_tests > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask

    task automatic bus(input logic w, input logic [3:0] a,
                       input logic [31:0] d);
        AVS_ADDRESS   <= a;
        AVS_WRITEDATA <= d;
        AVS_WRITE     <= w;
        AVS_READ      <= !w;
        do @(posedge CLK_SYS); while (AVS_WAITREQUEST !== 1'b0);
        rdat = AVS_READDATA;
        AVS_READ  <= 1'b0;
        AVS_WRITE <= 1'b0;
        @(posedge CLK_SYS);
    endtask

    task automatic rdchk(input logic [3:0] a, input logic [31:0] e);
        bus(1'b0, a, 32'h0);
        `CHK(rdat, e)
    endtask

    function automatic logic [31:0] pipe_exp(input logic [7:0] d,
                                             input logic [1:0] k);
        logic [1:0] v;
        for (int p = 0; p < 4; p++) begin
            v = d[2*p+:2];
            for (int j = 0; j < 4; j++)
                pipe_exp[8*p+2*j+:2] = (j == k) ? v : {2{^v}};
        end
    endfunction

    // ==========================================================
    // Watchdog and stream monitor
    always @(posedge CLK_SYS) begin
        cyc++;
        if (cyc == 20000) begin
            num_errors++;
            end_of_test();
        end
    end

    always @(posedge CLK_SYS) begin
        if (CONTROLLER_INIT === 1'b1) n_init++;
        run_n = (CYCLE_ACTIVE === 1'b1) ? run_n + 1 : 0;
        for (int p = 0; p < 4; p++)
            b[2*p+:2] = PIPE_DATA[8*p+2*INPUT_SELECT+:2];
        if (mon_on && run_n > 3) begin
            `CHK(b, prev + 8'h01)
            `CHK(PIPE_DATA, pipe_exp(b, INPUT_SELECT))
        end
        prev = b;
    end

    // ==========================================================
    // Main sequence
    initial begin
        repeat (16) @(posedge CLK_SYS);
        NRST <= 1'b1;
        repeat (3) @(posedge CLK_SYS);
        `CHK(CLK_SOURCE_SEL, `TTFS_CLK_XTAL)
        `CHK(CARD_SELECT_N, 1'b1)
        rdchk(`TTFS_REG_CTRL, 32'h0);
        rdchk(`TTFS_REG_STATUS, 32'h0);
        rdchk(`TTFS_REG_SEQ, 32'h0);
        rdchk(4'hf, 32'h0);
        $display("test reset done");
        for (int i = 0; i < 3; i++) begin
            bus(1'b1, `TTFS_REG_CTRL, i << 2);
            `CHK(CLK_SOURCE_SEL, i[1:0])
        end
        for (int i = 0; i < 6; i++) begin
            bus(1'b1, `TTFS_REG_ASIC_SEL, 32'h1 << i);
            `CHK({HALF_WORD_SELECT, ASIC_COLUMN_SELECT_1, ASIC_COLUMN_SELECT_0,
                ASIC_ROW_SELECT_1, ASIC_ROW_SELECT_0, CARD_SELECT_N},
                6'h01 << i)
        end
        $display("test select done");
        bus(1'b1, `TTFS_REG_PAT_ADDR, 32'h0);
        // Enough pattern for the first four transform cycles
        for (int i = 0; i < 2048; i++)
            bus(1'b1, `TTFS_REG_PAT_DATA, i & 32'hff);
        bus(1'b1, `TTFS_REG_RD_ADDR, 32'h5a3c);
        bus(1'b1, `TTFS_REG_ASIC_SEL, 32'h20);
        bus(1'b1, `TTFS_REG_CTRL, 32'h5);
        EXT_DATA_SEL <= 1'b1;
        for (int k = 0; k < 4; k++) begin
            INPUT_SELECT <= k[1:0];
            repeat (3) @(posedge CLK_SYS);
            @(negedge CLK_SYS);
            `CHK(PIPE_DATA, pipe_exp(8'hc6, k[1:0]))
            @(posedge CLK_SYS);
        end
        EXT_DATA_SEL <= 1'b0;
        INPUT_SELECT <= 2'h2;
        // External data chosen by the control bit instead of the switch
        bus(1'b1, `TTFS_REG_CTRL, 32'h7);
        repeat (3) @(posedge CLK_SYS);
        @(negedge CLK_SYS);
        `CHK(PIPE_DATA, pipe_exp(8'hc6, 2'h2))
        @(posedge CLK_SYS);
        bus(1'b1, `TTFS_REG_CTRL, 32'h5);
        repeat (4) @(posedge CLK_SYS);
        mon_on <= 1'b1;
        $display("test panel data done");
        do @(negedge CLK_SYS); while (SHORT_ACCUM_READ_STROBE !== 1'b1);
        `CHK(ACC_EXT_ADDR, 16'h5a3c)
        @(posedge CLK_SYS);
        rdchk(`TTFS_REG_HOLD_ADDR, 32'h5a3c);
        rdchk(`TTFS_REG_HOLD_DATA, 32'h1a5c3);
        bus(1'b1, `TTFS_REG_ASIC_SEL, 32'h0);
        $display("test readout done");
        EXPONENT_OVERFLOW_N <= 4'hd;
        repeat (3) @(posedge CLK_SYS);
        EXPONENT_OVERFLOW_N <= 4'hf;
        repeat (6) @(posedge CLK_SYS);
        rdchk(`TTFS_REG_STATUS, 32'h12);
        LAMP_RESET_BTN_N <= 1'b0;
        repeat (3) @(posedge CLK_SYS);
        LAMP_RESET_BTN_N <= 1'b1;
        repeat (6) @(posedge CLK_SYS);
        rdchk(`TTFS_REG_STATUS, 32'h10);
        $display("test lamps done");
        do @(negedge CLK_SYS); while (SHORT_ACCUM_READ_STROBE !== 1'b1);
        @(posedge CLK_SYS);
        // Read taken one edge later: cycle 2, pulse 1
        rdchk(`TTFS_REG_SEQ, 32'h801);
        rdchk(`TTFS_REG_HOLD_DATA, 32'h25a3c);
        `CHK(n_init, 1)
        $display("test stream done");
        end_of_test();
    end
endmodule // test_transform_test_fixture_sequencer

`default_nettype wire
